// ===== rtl/fcir_map.svh
// Constants for the serial flash configuration, identification and reset command block.
// Assumes inclusion by the main design file and the serial shifter file.
`ifndef FCIR_MAP_SVH
`define FCIR_MAP_SVH

// ----------------------------------------------------------------
// Opcodes and sequence bytes
// ----------------------------------------------------------------
`define FCIR_OP_CFG0       8'h3d
`define FCIR_OP_CFG1       8'h2a
`define FCIR_OP_CFG2       8'h80
`define FCIR_OP_CFG_BIN    8'ha6
`define FCIR_OP_CFG_EXT    8'ha7
`define FCIR_OP_ID         8'h9f
`define FCIR_OP_RST0       8'hf0
`define FCIR_OP_RST_ARG    8'h00
`define FCIR_EDI_LEN       8'h01

// ----------------------------------------------------------------
// Identification values (arbitrary, neutral)
// ----------------------------------------------------------------
`define FCIR_MFG_ID        8'h5a
`define FCIR_DEV_ID0       8'h11
`define FCIR_DEV_ID1       8'h22
`define FCIR_EDI_BYTE      8'h33

// ----------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------
`define FCIR_PAGE_BIN      10'h200
`define FCIR_PAGE_EXT      10'h210
`define FCIR_CLK_NS        10
`define FCIR_NV_PROG_NS    35000000
`define FCIR_NV_PROG_CYC   (`FCIR_NV_PROG_NS / `FCIR_CLK_NS)
`define FCIR_SW_RST_NS     30000
`define FCIR_SW_RST_CYC    (`FCIR_SW_RST_NS / `FCIR_CLK_NS)

`endif

// ===== rtl/fcir_pkg.sv
// Types for the serial flash configuration, identification and reset block.
// Assumes nothing beyond a SystemVerilog compiler.
package fcir_pkg;
  typedef enum logic [2:0] {
    FCIR_ST_OPCODE,
    FCIR_ST_CFG,
    FCIR_ST_RST,
    FCIR_ST_ID,
    FCIR_ST_IGNORE
  } fcir_cmd_e;

  typedef enum logic [1:0] {
    FCIR_OP_NONE,
    FCIR_OP_PROG,
    FCIR_OP_RESET
  } fcir_op_e;
endpackage

// ===== rtl/fcir_serial_if.sv
// Byte link between the serial shifter and the command decoder.
// Assumes one system clock for both ends.
`timescale 1ns/1ps
interface fcir_serial_if;
  logic       sel;        // Chip select active, synchronised
  logic       frame_end;  // Pulse: select just released
  logic       on_bound;   // Bit count was a multiple of eight at release
  logic       byte_vld;   // Pulse: one byte received
  logic [7:0] byte_in;    // Received byte
  logic       tx_load;    // Pulse: load tx_byte at next fall
  logic [7:0] tx_byte;    // Byte to shift out
  logic       tx_en;      // Output enabled

  modport shifter (output sel, frame_end, on_bound, byte_vld, byte_in, input tx_load, tx_byte, tx_en);
  modport decoder (input sel, frame_end, on_bound, byte_vld, byte_in, output tx_load, tx_byte, tx_en);
endinterface

// ===== rtl/fcir_shifter.sv
// Serial pin shifter: synchronises select, clock and data; assembles and emits bytes.
// Assumes serial pins asynchronous to clk, sampled well above the serial rate, mode 0.
`timescale 1ns/1ps
`include "fcir_map.svh"
module fcir_shifter
  import fcir_pkg::*;
(
  input  wire logic      clk,        // System clock
  input  wire logic      reset,      // Async reset, active high
  input  wire logic      cs_n,       // Chip select pin, active low
  input  wire logic      sck,        // Serial clock pin
  input  wire logic      si,         // Serial data in pin
  output logic           so_o,       // Serial data out
  output logic           so_oe_n,    // Output enable, low drives
  fcir_serial_if.shifter lnk         // Byte link
);
  logic [2:0] cs_s_q, cs_s_d, sck_s_q, sck_s_d, si_s_q, si_s_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d;
  logic       so_q, so_d, oe_n_q, oe_n_d, ld_q, ld_d;
  logic       rise, fall, sel;

  // ----------------------------------------------------------------
  // Synchronisers and shifting
  // ----------------------------------------------------------------
  assign sel  = ~cs_s_q[1];
  assign rise = sel & sck_s_q[1] & ~sck_s_q[2];
  assign fall = sel & ~sck_s_q[1] & sck_s_q[2];

  // Next values for pins, bit counter and shift registers
  always_comb begin
    cs_s_d  = {cs_s_q[1:0], cs_n};
    sck_s_d = {sck_s_q[1:0], sck};
    si_s_d  = {si_s_q[1:0], si};
    bit_d   = sel ? bit_q : 3'h0;
    sh_d    = sh_q;
    tx_d    = tx_q;
    so_d    = so_q;
    ld_d    = ld_q | lnk.tx_load;
    oe_n_d  = ~(sel & lnk.tx_en);
    if (rise) begin
      sh_d  = {sh_q[6:0], si_s_q[1]};
      bit_d = bit_q + 3'h1;
    end
    if (fall && lnk.tx_en) begin
      if (ld_q) begin
        so_d = lnk.tx_byte[7];
        tx_d = {lnk.tx_byte[6:0], 1'b0};
        ld_d = 1'b0;
      end else begin
        so_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
      end
    end
    if (!sel) ld_d = 1'b0;
  end

  // Register stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cs_s_q <= 3'h7; sck_s_q <= 3'h0; si_s_q <= 3'h0;
      bit_q <= 3'h0; sh_q <= 8'h00; tx_q <= 8'h00;
      so_q <= 1'b0; oe_n_q <= 1'b1; ld_q <= 1'b0;
    end else begin
      cs_s_q <= cs_s_d; sck_s_q <= sck_s_d; si_s_q <= si_s_d;
      bit_q <= bit_d; sh_q <= sh_d; tx_q <= tx_d;
      so_q <= so_d; oe_n_q <= oe_n_d; ld_q <= ld_d;
    end
  end

  assign so_o          = so_q;
  assign so_oe_n       = oe_n_q;
  assign lnk.sel       = sel;
  assign lnk.frame_end = cs_s_q[1] & ~cs_s_q[2];
  assign lnk.on_bound  = (bit_q == 3'h0);
  assign lnk.byte_vld  = rise & (bit_q == 3'h7);
  assign lnk.byte_in   = {sh_q[6:0], si_s_q[1]};
endmodule

// ===== rtl/fcir_top.sv
// Command block of a serial flash: page size configuration, identification readout, software reset.
// Assumes an SPI mode 0 host on the pins and a flash core on the status and abort ports.
`timescale 1ns/1ps
`include "fcir_map.svh"
module fcir_top
  import fcir_pkg::*;
#(
  parameter int unsigned NV_PROG_CYC = `FCIR_NV_PROG_CYC,   // Nonvolatile program time in cycles
  parameter int unsigned SW_RST_CYC  = `FCIR_SW_RST_CYC     // Reset abort time in cycles
) (
  input  wire logic       clk,                   // System clock, 100 MHz
  input  wire logic       reset,                 // Async reset, active high
  input  wire logic       cs_n,                  // Chip select pin, active low
  input  wire logic       sck,                   // Serial clock pin
  input  wire logic       si,                    // Serial data in pin
  output logic            so_o,                  // Serial data out
  output logic            so_oe_n,               // Serial out enable, low drives
  input  wire logic       nv_binary_strap,       // Preconfigured binary size
  input  wire logic       core_busy,             // Flash core program or erase running
  input  wire logic       core_prog_susp,        // Core program suspended
  input  wire logic       core_erase_susp,       // Core erase suspended
  input  wire logic       core_buf2_sel,         // Suspended program used buffer 2
  output logic            core_abort,            // Abort core operation, level
  output logic            ready_busy_n,          // Status ready, low busy
  output logic            page_binary,           // Status: 512-byte pages
  output logic [9:0]      page_size,             // Current page and buffer size
  output logic            buf1_prog_suspended_flag, // Status suspend flag, buffer 1
  output logic            buf2_prog_suspended_flag, // Status suspend flag, buffer 2
  output logic            erase_suspended_flag,     // Status erase-suspend flag
  output logic            nv_program_pulse       // Pulse: nonvolatile write starts
);
  fcir_serial_if lnk ();

  fcir_shifter u_shift (
    .clk     (clk),
    .reset   (reset),
    .cs_n    (cs_n),
    .sck     (sck),
    .si      (si),
    .so_o    (so_o),
    .so_oe_n (so_oe_n),
    .lnk     (lnk)
  );

  // ----------------------------------------------------------------
  // Command decode state
  // ----------------------------------------------------------------
  fcir_cmd_e   st_q, st_d;
  fcir_op_e    op_q, op_d;
  logic [1:0]  idx_q, idx_d;
  logic [2:0]  id_q, id_d;
  logic        cfg_ok_q, cfg_ok_d, cfg_bin_q, cfg_bin_d, rst_ok_q, rst_ok_d;
  logic        nv_bin_q, nv_bin_d, pend_bin_q, pend_bin_d, init_q, init_d;
  logic [31:0] cnt_q, cnt_d;
  logic        abort_q, abort_d, prog_q, prog_d;
  logic        s1_q, s1_d, s2_q, s2_d, es_q, es_d;
  logic        sw_rst;
  logic [7:0]  id_byte;

  // Identification byte selector
  always_comb begin
    case (id_q)
      3'h0:    id_byte = `FCIR_MFG_ID;
      3'h1:    id_byte = `FCIR_DEV_ID0;
      3'h2:    id_byte = `FCIR_DEV_ID1;
      3'h3:    id_byte = `FCIR_EDI_LEN;
      default: id_byte = `FCIR_EDI_BYTE;
    endcase
  end
  assign lnk.tx_byte = id_byte;
  assign lnk.tx_en   = (st_q == FCIR_ST_ID) && (id_q <= 3'h5) && !(id_q == 3'h5);
  assign lnk.tx_load = (st_q == FCIR_ST_ID) && lnk.byte_vld && (id_q < 3'h4) || (st_d == FCIR_ST_ID && st_q != FCIR_ST_ID);

  // Byte sequence decoder
  always_comb begin
    st_d     = st_q;
    idx_d    = idx_q;
    id_d     = id_q;
    cfg_ok_d = 1'b0;
    cfg_bin_d = cfg_bin_q;
    rst_ok_d = 1'b0;
    if (!lnk.sel) begin
      st_d  = FCIR_ST_OPCODE;
      idx_d = 2'h0;
      id_d  = 3'h0;
    end else if (lnk.byte_vld) begin
      case (st_q)
        FCIR_ST_OPCODE: begin
          idx_d = 2'h1;
          if (lnk.byte_in == `FCIR_OP_CFG0 && op_q != FCIR_OP_PROG) st_d = FCIR_ST_CFG;
          else if (lnk.byte_in == `FCIR_OP_RST0) st_d = FCIR_ST_RST;
          else if (lnk.byte_in == `FCIR_OP_ID && op_q != FCIR_OP_PROG) st_d = FCIR_ST_ID;
          else st_d = FCIR_ST_IGNORE;
        end
        FCIR_ST_CFG: begin
          idx_d = idx_q + 2'h1;
          if (idx_q == 2'h1 && lnk.byte_in != `FCIR_OP_CFG1) st_d = FCIR_ST_IGNORE;
          if (idx_q == 2'h2 && lnk.byte_in != `FCIR_OP_CFG2) st_d = FCIR_ST_IGNORE;
          if (idx_q == 2'h3) begin
            st_d = FCIR_ST_IGNORE;
            if (lnk.byte_in == `FCIR_OP_CFG_BIN || lnk.byte_in == `FCIR_OP_CFG_EXT) begin
              cfg_ok_d  = 1'b1;
              cfg_bin_d = (lnk.byte_in == `FCIR_OP_CFG_BIN);
            end
          end
        end
        FCIR_ST_RST: begin
          idx_d = idx_q + 2'h1;
          if (lnk.byte_in != `FCIR_OP_RST_ARG) st_d = FCIR_ST_IGNORE;
          else if (idx_q == 2'h3) begin
            st_d     = FCIR_ST_IGNORE;
            rst_ok_d = 1'b1;
          end
        end
        FCIR_ST_ID: if (id_q < 3'h5) id_d = id_q + 3'h1;
        default: st_d = st_q;
      endcase
    end
    // Armed sequences survive trailing bytes while select stays active
    if (lnk.sel && !(lnk.byte_vld && st_q != FCIR_ST_IGNORE)) begin
      cfg_ok_d = cfg_ok_q;
      rst_ok_d = rst_ok_q;
    end
    if (lnk.sel && st_q == FCIR_ST_IGNORE) begin
      cfg_ok_d = cfg_ok_q;
      rst_ok_d = rst_ok_q;
    end
  end

  assign sw_rst = lnk.frame_end && lnk.on_bound && rst_ok_q;

  // ----------------------------------------------------------------
  // Self-timed operations and nonvolatile size
  // ----------------------------------------------------------------
  always_comb begin
    op_d       = op_q;
    cnt_d      = cnt_q;
    nv_bin_d   = nv_bin_q;
    pend_bin_d = pend_bin_q;
    init_d     = 1'b1;
    prog_d     = 1'b0;
    abort_d    = abort_q;
    s1_d       = core_prog_susp & ~core_buf2_sel;
    s2_d       = core_prog_susp & core_buf2_sel;
    es_d       = core_erase_susp;
    if (!init_q) nv_bin_d = nv_binary_strap;
    case (op_q)
      FCIR_OP_NONE: begin
        if (lnk.frame_end && lnk.on_bound && cfg_ok_q) begin
          op_d       = FCIR_OP_PROG;
          pend_bin_d = cfg_bin_q;
          cnt_d      = NV_PROG_CYC - 1;
          prog_d     = 1'b1;
        end else if (sw_rst) begin
          op_d    = FCIR_OP_RESET;
          cnt_d   = SW_RST_CYC - 1;
          abort_d = 1'b1;
        end
      end
      FCIR_OP_PROG: begin
        if (cnt_q == 32'h0) begin
          op_d     = FCIR_OP_NONE;
          nv_bin_d = pend_bin_q;
        end else cnt_d = cnt_q - 32'h1;
      end
      FCIR_OP_RESET: begin
        if (cnt_q == 32'h0) begin
          op_d    = FCIR_OP_NONE;
          abort_d = 1'b0;
        end else cnt_d = cnt_q - 32'h1;
      end
      default: op_d = FCIR_OP_NONE;
    endcase
    if (abort_q || sw_rst) begin
      s1_d = 1'b0;
      s2_d = 1'b0;
      es_d = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= FCIR_ST_OPCODE; idx_q <= 2'h0; id_q <= 3'h0;
      cfg_ok_q <= 1'b0; cfg_bin_q <= 1'b0; rst_ok_q <= 1'b0;
      op_q <= FCIR_OP_NONE; cnt_q <= 32'h0; nv_bin_q <= 1'b0;
      pend_bin_q <= 1'b0; init_q <= 1'b0; prog_q <= 1'b0; abort_q <= 1'b0;
      s1_q <= 1'b0; s2_q <= 1'b0; es_q <= 1'b0;
    end else begin
      st_q <= st_d; idx_q <= idx_d; id_q <= id_d;
      cfg_ok_q <= cfg_ok_d; cfg_bin_q <= cfg_bin_d; rst_ok_q <= rst_ok_d;
      op_q <= op_d; cnt_q <= cnt_d; nv_bin_q <= nv_bin_d;
      pend_bin_q <= pend_bin_d; init_q <= init_d; prog_q <= prog_d; abort_q <= abort_d;
      s1_q <= s1_d; s2_q <= s2_d; es_q <= es_d;
    end
  end

  // Output registers for status
  logic       rdy_q, bin_q;
  logic [9:0] size_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdy_q  <= 1'b0;
      bin_q  <= 1'b0;
      size_q <= `FCIR_PAGE_EXT;
    end else begin
      rdy_q  <= (op_d != FCIR_OP_PROG) & ~core_busy;
      bin_q  <= nv_bin_d;
      size_q <= nv_bin_d ? `FCIR_PAGE_BIN : `FCIR_PAGE_EXT;
    end
  end

  assign ready_busy_n             = rdy_q;
  assign page_binary              = bin_q;
  assign page_size                = size_q;
  assign core_abort               = abort_q;
  assign nv_program_pulse         = prog_q;
  assign buf1_prog_suspended_flag = s1_q;
  assign buf2_prog_suspended_flag = s2_q;
  assign erase_suspended_flag     = es_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_prog_starts_busy: assert property (@(posedge clk) disable iff (reset)
    prog_q |-> !ready_busy_n) else $error("busy not shown at program start");
  a_prog_on_release: assert property (@(posedge clk) disable iff (reset)
    $rose(prog_q) |-> $past(lnk.frame_end)) else $error("program began without release");
  a_abort_on_release: assert property (@(posedge clk) disable iff (reset)
    $rose(abort_q) |-> $past(lnk.frame_end) && $past(lnk.on_bound)) else $error("reset without release");
  a_flags_cleared: assert property (@(posedge clk) disable iff (reset)
    $rose(abort_q) |-> !erase_suspended_flag && !buf1_prog_suspended_flag) else $error("suspend flags kept");
  a_size_binary: assert property (@(posedge clk) disable iff (reset)
    page_binary |-> page_size == `FCIR_PAGE_BIN) else $error("size mismatch binary");
  a_size_ext: assert property (@(posedge clk) disable iff (reset)
    !page_binary |-> page_size == `FCIR_PAGE_EXT) else $error("size mismatch extended");
  a_id_float: assert property (@(posedge clk) disable iff (reset)
    !lnk.sel |=> ##1 so_oe_n) else $error("output driven after release");
  a_size_kept: assert property (@(posedge clk) disable iff (reset)
    abort_q && op_q == FCIR_OP_RESET |=> $stable(page_binary)) else $error("reset changed page size");
  c_cfg_prog: cover property (@(posedge clk) disable iff (reset) prog_q);
  c_sw_reset: cover property (@(posedge clk) disable iff (reset) $rose(abort_q));
  c_id_read:  cover property (@(posedge clk) disable iff (reset) !so_oe_n);
endmodule

// ===== verification/fcir_host.sv
// Serial host model: drives select, serial clock and data in mode 0, samples the serial output.
// Assumes the bench clock; the serial clock idles low between frames and runs far below clk.
`timescale 1ns/1ps
module fcir_host (
  input  wire logic clk,      // Bench clock
  output logic      cs_n,     // Chip select, active low
  output logic      sck,      // Serial clock
  output logic      si,       // Serial data to device
  input  wire logic so_o,     // Serial data from device
  input  wire logic so_oe_n   // Device output enable, low drives
);
  // ----------------------------------------------------------------
  // Frame tasks
  // ----------------------------------------------------------------
  localparam int HALF = 8;

  // Idle levels at time zero
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // Wait n falling clock edges
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Keep select high a while, then open a frame
  task automatic select();
    idle(HALF);
    cs_n = 1'b0;
    idle(HALF);
  endtask

  // Shift n bits MSB first; capture bits and count driven ones
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx, output int drv);
    rx  = 8'h00;
    drv = 0;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      idle(HALF);
      sck   = 1'b1;
      rx[i] = so_o;
      if (so_oe_n === 1'b0) drv++;
      idle(HALF);
      sck = 1'b0;
    end
  endtask

  // Release select after the last bit; data line goes stale
  task automatic end_frame();
    idle(HALF);
    cs_n = 1'b1;
    si   = ~si;
  endtask

  // Frame of up to five bytes cut after nbits, optionally left open
  task automatic send(input logic [39:0] w, input int nbits, input logic close);
    logic [7:0] rx;
    int         drv;
    select();
    for (int b = 0; b < 5 && nbits > 8 * b; b++) begin
      bits(w[39 - 8 * b -: 8], (nbits - 8 * b > 8) ? 8 : nbits - 8 * b, rx, drv);
    end
    if (close) end_frame();
  endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the command block: size config, identification, software reset.
// Assumes the host model in fcir_host and shortened program and abort counts.
`timescale 1ns/1ps
`include "fcir_map.svh"
module tb;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int NV_CYC  = 20;  // Shortened program time
  localparam int RST_CYC = 10;  // Shortened abort time

  logic       clk             = 1'b0;
  logic       reset           = 1'b1;
  logic       nv_binary_strap = 1'b0;
  logic       core_busy       = 1'b0;
  logic       core_prog_susp  = 1'b0;
  logic       core_erase_susp = 1'b0;
  logic       core_buf2_sel   = 1'b0;
  logic       cs_n, sck, si, so_o, so_oe_n, core_abort, ready_busy_n, page_binary;
  logic       buf1_prog_suspended_flag, buf2_prog_suspended_flag, erase_suspended_flag, nv_program_pulse;
  logic [9:0] page_size;
  int         err_count       = 0;
  int         n_checks        = 0;

  fcir_top #(.NV_PROG_CYC(NV_CYC), .SW_RST_CYC(RST_CYC)) DUT (
    .clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o), .so_oe_n(so_oe_n),
    .nv_binary_strap(nv_binary_strap), .core_busy(core_busy), .core_prog_susp(core_prog_susp),
    .core_erase_susp(core_erase_susp), .core_buf2_sel(core_buf2_sel), .core_abort(core_abort),
    .ready_busy_n(ready_busy_n), .page_binary(page_binary), .page_size(page_size),
    .buf1_prog_suspended_flag(buf1_prog_suspended_flag), .buf2_prog_suspended_flag(buf2_prog_suspended_flag),
    .erase_suspended_flag(erase_suspended_flag), .nv_program_pulse(nv_program_pulse));

  fcir_host host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o), .so_oe_n(so_oe_n));

  // 100 MHz clock
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Compare, wait and verdict tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Bounded wait for the program pulse (0) or the abort level (1)
  task automatic wait_sig(input int s, input int lim);
    int n;
    n = 0;
    while (((s == 0) ? nv_program_pulse : core_abort) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        err_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        give_verdict();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    chk_val(page_size, 10'h210);
    chk_bit(page_binary, 1'b0);
    chk_bit(so_oe_n, 1'b1);
    chk_bit(core_abort, 1'b0);
    chk_bit(ready_busy_n, 1'b1);
  endtask

  // Size change: nothing before release, busy for the program time, new size after
  task automatic t_config(input logic [7:0] last, input logic [9:0] size);
    int n;
    host.send({24'h3d2a80, last, 8'h00}, 32, 1'b0);
    repeat (6) @(negedge clk);
    chk_bit(ready_busy_n, 1'b1);
    host.end_frame();
    wait_sig(0, 12);
    @(negedge clk);
    chk_bit(ready_busy_n, 1'b0);
    n = 0;
    while (ready_busy_n === 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk_bit(n >= NV_CYC - 3 && n <= NV_CYC + 1, 1'b1);
    repeat (3) @(negedge clk);
    chk_val(page_size, size);
    chk_bit(page_binary, size == 10'h200);
  endtask

  // Readout cut mid-byte, then floated
  task automatic t_id_abort();
    logic [7:0] rx;
    int         drv;
    host.select();
    host.bits(8'h9f, 8, rx, drv);
    host.bits(8'h00, 3, rx, drv);
    chk_val(10'(drv), 10'h003);
    host.end_frame();
    repeat (6) @(negedge clk);
    chk_bit(so_oe_n, 1'b1);
  endtask

  // Full readout, order and float afterwards
  task automatic t_id();
    logic [7:0] rx;
    logic [7:0] exp [5];
    int         drv;
    exp = '{`FCIR_MFG_ID, `FCIR_DEV_ID0, `FCIR_DEV_ID1, 8'h01, `FCIR_EDI_BYTE};
    host.select();
    host.bits(8'h9f, 8, rx, drv);
    chk_val(10'(drv), 10'h000);
    for (int i = 0; i < 5; i++) begin
      host.bits(8'h00, 8, rx, drv);
      chk_val({2'b00, rx}, {2'b00, exp[i]});
      chk_val(10'(drv), 10'h008);
    end
    host.bits(8'h00, 8, rx, drv);
    chk_val(10'(drv), 10'h000);
    host.end_frame();
  endtask

  // Wrong, short and off-boundary sequences do nothing
  task automatic t_refused();
    logic [39:0] seq [7];
    int          len [7];
    int          hit;
    seq = '{40'h3d2a81a600, 40'h3d2b80a600, 40'h3d2a80a800, 40'h3d2a80a600,
            40'hf000000000, 40'hf000010000, 40'hf000000000};
    len = '{32, 32, 32, 28, 24, 32, 35};
    for (int k = 0; k < 7; k++) begin
      host.send(seq[k], len[k], 1'b1);
      hit = 0;
      repeat (30) begin
        @(negedge clk);
        if (nv_program_pulse !== 1'b0 || core_abort !== 1'b0) hit++;
      end
      chk_val(10'(hit), 10'h000);
      chk_val(page_size, 10'h210);
    end
  endtask

  // Reset with trailing byte, once per suspend buffer
  task automatic t_swreset();
    int n;
    for (int s = 0; s < 2; s++) begin
      core_busy       = 1'b1;
      core_prog_susp  = 1'b1;
      core_erase_susp = 1'b1;
      core_buf2_sel   = s[0];
      repeat (4) @(negedge clk);
      chk_bit(ready_busy_n, 1'b0);
      chk_bit(buf1_prog_suspended_flag, ~s[0]);
      chk_bit(buf2_prog_suspended_flag, s[0]);
      chk_bit(erase_suspended_flag, 1'b1);
      host.send(40'hf0000000_3d, 40, 1'b1);
      wait_sig(1, 12);
      chk_bit(buf1_prog_suspended_flag, 1'b0);
      chk_bit(buf2_prog_suspended_flag, 1'b0);
      chk_bit(erase_suspended_flag, 1'b0);
      core_busy       = 1'b0;
      core_prog_susp  = 1'b0;
      core_erase_susp = 1'b0;
      n = 0;
      while (core_abort === 1'b1 && n < 100) begin
        @(negedge clk);
        n++;
      end
      chk_bit(n >= RST_CYC - 1 && n <= RST_CYC + 1, 1'b1);
      chk_val(page_size, 10'h210);
      chk_bit(ready_busy_n, 1'b1);
    end
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    repeat (3) @(negedge clk);
    t_reset_values();
    t_config(8'ha6, 10'h200);
    t_config(8'ha7, 10'h210);
    t_id_abort();
    t_id();
    t_refused();
    t_swreset();
    give_verdict();
  end
endmodule
